// [design/boundary_scan_test_logic.sv]
// Purpose: instruction and data registers behind the four-wire test port
// Assumes: the controller state machine sits outside and drives tapState
// Notes: test-clock logic needs no core clock; pad muxing is combinational
//
// Overview of operation
// RULE1: instruction register is four bits wide
// RULE2: all shift paths move LSB first
// RULE3: bypass is one cell, captures zero
// RULE4: code 0xf selects bypass cell
// RULE5: code 0x1 selects 32-bit identification word
// RULE6: instruction resets to identification code
// RULE7: version field counts silicon revisions
// RULE8: part number is fixed 16-bit field
// RULE9: manufacturer is fixed 11-bit field
// RULE10: code 0x0 drives chain onto pins
// RULE11: chain exposes each pin's control and data
// RULE12: code 0x2 samples, latches stay disconnected
// RULE13: code 0xc selects reset cell only
// RULE14: reset cell holds chip in reset directly
// RULE15: reset lasts start-up time-out after release
// RULE16: chip reset tri-states all port outputs; under code 0x0 the pads still follow the chain latches
// RULE17: port enabled by fuse and clear disable
// RULE18: disable bit changes on double write
// RULE19: cause bit 4 flags test reset
// RULE20: two-stage cell, pullups off in test
// RULE21: capture raw pin, pullup from port terms
// RULE22: no clock output during test modes
// RULE23: works with core clock stopped
// RULE24: identification word field positions fixed
// RULE25: undefined codes select bypass
`timescale 1ns/100ps
module boundary_scan_test_logic #(
	parameter int PIN_COUNT = 4
) (
	// core clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// test port link
	input wire logic tck,
	input wire logic tdi,
	input wire boundary_scan_pkg::tap_state_s tapState,
	output logic tdo,
	output logic tdoOe,
	output logic tapEnable,
	// fuses
	input wire logic testPortFuse,
	input wire logic clockOutFuse,
	input wire logic longStartupFuse,
	// core register access
	input wire logic ctrlWrite,
	input wire logic causeWrite,
	input wire logic [7:0] writeData,
	output logic [7:0] coreControl,
	output logic [7:0] resetCause,
	// reset requests
	output logic chipResetReq,
	output logic coreReset,
	// port pins and port registers
	input wire logic [PIN_COUNT-1:0] pinIn,
	input wire logic [PIN_COUNT-1:0] portOut,
	input wire logic [PIN_COUNT-1:0] portDir,
	input wire logic pullupDisable,
	output logic [PIN_COUNT-1:0] padOut,
	output logic [PIN_COUNT-1:0] padOe,
	output logic [PIN_COUNT-1:0] padPullup,
	output logic clockOutEnable
);
	import boundary_scan_pkg::*;

	localparam int CHAIN_LEN = 2 * PIN_COUNT;
	localparam int DR_LEN = (CHAIN_LEN > ID_WIDTH) ? CHAIN_LEN : ID_WIDTH;

	typedef struct packed {
		logic [1:0] enSync;
		opcode_t ir;
		opcode_t irShift;
		logic [DR_LEN-1:0] dr;
		logic resetBit;
		logic [PIN_COUNT-1:0] bsOut;
		logic [PIN_COUNT-1:0] bsOe;
		logic tdo;
		logic tdoOe;
	} tck_s;

	typedef struct packed {
		logic [1:0] rstSync;
		logic portEnable;
		logic coreReset;
		logic [TIMEOUT_WIDTH-1:0] timeout;
		logic [7:0] control;
		logic [7:0] cause;
		logic [2:0] armCount;
		logic armValue;
	} core_s;

	localparam tck_s TCK_RESET = '{ir: OP_IDCODE, irShift: OP_IDCODE, default: '0};
	localparam core_s CORE_RESET = '{control: CONTROL_RESET, cause: CAUSE_RESET, default: '0};

	tck_s t;
	tck_s next_t;
	core_s c;
	core_s next_c;

	// length of the data path that an instruction selects
	function automatic int pathLen(input opcode_t op);
		int len;
		len = 1;
		if (op == OP_IDCODE) begin
			len = ID_WIDTH;
		end else if (op == OP_EXTEST || op == OP_SAMPLE) begin
			len = CHAIN_LEN;
		end
		return len;
	endfunction

	// shift one bit in at the top of the selected length, lsb falls out
	function automatic logic [DR_LEN-1:0] shiftPath(input logic [DR_LEN-1:0] v,
			input logic din, input int len);
		logic [DR_LEN-1:0] r;
		r = v;
		for (int k = 0; k < DR_LEN; k++) begin
			if (k == len - 1) begin
				r[k] = din;
			end else if (k < len - 1) begin
				r[k] = v[k+1];
			end
		end
		return r;
	endfunction

	logic extMode;
	logic sampleMode;
	logic inReset;
	logic testMode;
	assign extMode = (t.ir == OP_EXTEST);
	assign sampleMode = (t.ir == OP_SAMPLE);
	assign testMode = extMode | sampleMode;
	assign inReset = t.resetBit | c.coreReset;

	// test-clock domain: instruction, data paths, reset cell, update latches
	always_comb begin
		next_t = t;
		next_t.enSync = {t.enSync[0], c.portEnable};
		if (!t.enSync[1] || tapState.tapReset) begin
			next_t.ir = OP_IDCODE; // RULE6
			next_t.irShift = OP_IDCODE;
			next_t.resetBit = 1'b0;
			next_t.tdoOe = 1'b0;
		end else begin
			if (tapState.captureIr) begin
				next_t.irShift = IR_CAPTURE_VALUE;
			end else if (tapState.shiftIr) begin
				next_t.irShift = {tdi, t.irShift[IR_WIDTH-1:1]}; // RULE1 RULE2
			end
			// loading any code leaves the controller state alone
			if (tapState.updateIr) begin
				next_t.ir = t.irShift; // RULE13
			end
			if (tapState.captureDr) begin
				if (t.ir == OP_IDCODE) begin
					next_t.dr[ID_WIDTH-1:0] = ID_WORD; // RULE5 RULE7 RULE8 RULE9 RULE24
				end else if (extMode || sampleMode) begin
					// data cell takes the raw pin, no synchroniser
					for (int i = 0; i < PIN_COUNT; i++) begin
						next_t.dr[2*i] = padOe[i]; // RULE11 RULE20
						next_t.dr[2*i+1] = pinIn[i]; // RULE10 RULE12 RULE21
					end
				end else if (t.ir != OP_CHIP_RESET) begin
					next_t.dr[0] = 1'b0; // RULE3 RULE4 RULE25
				end
			end else if (tapState.shiftDr) begin
				if (t.ir == OP_CHIP_RESET) begin
					next_t.resetBit = tdi; // RULE13 RULE14
				end else begin
					next_t.dr = shiftPath(t.dr, tdi, pathLen(t.ir)); // RULE2
				end
			end
			if (tapState.updateDr && (extMode || sampleMode)) begin
				for (int i = 0; i < PIN_COUNT; i++) begin
					next_t.bsOe[i] = t.dr[2*i]; // RULE12
					next_t.bsOut[i] = t.dr[2*i+1];
				end
			end
			next_t.tdoOe = tapState.shiftIr | tapState.shiftDr;
		end
		// tdo shows the lsb of the selected path after this edge; a disabled or
		// resetting port keeps it low so a stale data cell never leaks out
		if (!t.enSync[1] || tapState.tapReset) begin
			next_t.tdo = 1'b0;
		end else if (tapState.shiftIr || tapState.captureIr) begin
			next_t.tdo = next_t.irShift[0];
		end else if (t.ir == OP_CHIP_RESET) begin
			next_t.tdo = next_t.resetBit;
		end else begin
			next_t.tdo = next_t.dr[0];
		end
	end

	// no core clock is needed here, so scans run with the chip stopped
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			t <= TCK_RESET;
		end else begin
			t <= next_t; // RULE23
		end
	end

	// core domain: reset stretch, cause flag, guarded disable bit
	always_comb begin
		next_c = c;
		next_c.rstSync = {c.rstSync[0], t.resetBit};
		next_c.portEnable = testPortFuse & ~c.control[DISABLE_BIT]; // RULE17
		if (c.rstSync[1]) begin
			next_c.timeout = longStartupFuse ? TIMEOUT_WIDTH'(STARTUP_LONG_CYC)
				: TIMEOUT_WIDTH'(STARTUP_SHORT_CYC); // RULE15
		end else if (c.timeout != '0) begin
			next_c.timeout = c.timeout - 1'b1;
		end
		next_c.coreReset = c.rstSync[1] | (c.timeout != '0); // RULE14 RULE15
		// software clear loses to a fresh test reset
		if (causeWrite && !writeData[RESET_FLAG_BIT]) begin
			next_c.cause[RESET_FLAG_BIT] = 1'b0;
		end
		if (c.rstSync[1]) begin
			next_c.cause[RESET_FLAG_BIT] = 1'b1; // RULE19
		end
		// a stray single write must not flip the port off
		if (ctrlWrite) begin
			next_c.control[DISABLE_BIT-1:0] = writeData[DISABLE_BIT-1:0];
			if (c.armCount != '0 && writeData[DISABLE_BIT] == c.armValue) begin
				next_c.control[DISABLE_BIT] = c.armValue; // RULE17 RULE18
				next_c.armCount = '0;
			end else begin
				next_c.armValue = writeData[DISABLE_BIT];
				next_c.armCount = DISABLE_WINDOW;
			end
		end else if (c.armCount != '0) begin
			next_c.armCount = c.armCount - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			c <= CORE_RESET;
		end else begin
			c <= next_c;
		end
	end

	// pad steering; reset tri-states unless the chain owns the pins
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (extMode) begin
				padOe[i] = t.bsOe[i]; // RULE10
				padOut[i] = t.bsOut[i];
			end else begin
				padOe[i] = portDir[i] & ~inReset; // RULE16
				padOut[i] = portOut[i];
			end
			padPullup[i] = ~pullupDisable & ~portDir[i] & portOut[i] & ~testMode; // RULE20 RULE21
		end
		clockOutEnable = clockOutFuse & ~testMode; // RULE22
	end

	assign tdo = t.tdo;
	assign tdoOe = t.tdoOe;
	assign tapEnable = c.portEnable;
	assign chipResetReq = t.resetBit; // RULE14
	assign coreReset = c.coreReset;
	assign coreControl = c.control;
	assign resetCause = c.cause;

	// checks on the test-clock side
	sequence idCapture;
		tapState.captureDr && t.enSync[1] && !tapState.tapReset && t.ir == OP_IDCODE;
	endsequence
	sequence shiftStep;
		tapState.shiftDr && t.enSync[1] && !tapState.tapReset && !tapState.captureDr;
	endsequence
	sequence irCapture;
		tapState.captureIr && t.enSync[1] && !tapState.tapReset;
	endsequence
	sequence irShiftStep;
		tapState.shiftIr && t.enSync[1] && !tapState.tapReset && !tapState.captureIr;
	endsequence
	sequence irLoad;
		tapState.updateIr && t.enSync[1] && !tapState.tapReset && !tapState.shiftIr;
	endsequence
	// chain steps only count while external test or sample is loaded
	sequence chainCapture;
		tapState.captureDr && t.enSync[1] && !tapState.tapReset && testMode;
	endsequence
	sequence latchLoad;
		tapState.updateDr && t.enSync[1] && !tapState.tapReset && testMode;
	endsequence

	chk_ir_default: assert property ( // RULE6
		@(posedge tck) disable iff (rst) tapState.tapReset |=> t.ir == OP_IDCODE)
		else $error("instruction not identification after controller reset");
	chk_id_capture: assert property ( // RULE5
		@(posedge tck) disable iff (rst) idCapture |=> t.dr[ID_WIDTH-1:0] == ID_WORD && tdo)
		else $error("identification word not captured");
	chk_id_shift: assert property ( // RULE2
		@(posedge tck) disable iff (rst) idCapture ##1 (shiftStep and t.ir == OP_IDCODE)
		|=> tdo == ID_WORD[1])
		else $error("identification not shifted lsb first");
	chk_bypass_zero: assert property ( // RULE3
		@(posedge tck) disable iff (rst)
		tapState.captureDr && t.enSync[1] && !tapState.tapReset && t.ir == OP_BYPASS
		|=> t.dr[0] == 1'b0 && !tdo)
		else $error("bypass cell not cleared on capture");
	chk_undef_bypass: assert property ( // RULE25
		@(posedge tck) disable iff (rst)
		(shiftStep and t.ir == 4'h5) ##1 (shiftStep and t.ir == 4'h5) |-> tdo == $past(tdi))
		else $error("undefined code not a single-cell path");
	chk_reset_cell: assert property ( // RULE13
		@(posedge tck) disable iff (rst) (shiftStep and t.ir == OP_CHIP_RESET)
		|=> chipResetReq == $past(tdi))
		else $error("reset cell not loaded from tdi");
	chk_clock_gate: assert property ( // RULE22
		@(posedge tck) disable iff (rst) testMode |-> !clockOutEnable)
		else $error("clock output active in test mode");
	chk_ir_capture: assert property ( // RULE1
		@(posedge tck) disable iff (rst) irCapture |=> t.irShift == IR_CAPTURE_VALUE && tdo)
		else $error("instruction capture value not loaded");
	chk_ir_shift: assert property ( // RULE2
		@(posedge tck) disable iff (rst) irCapture ##1 irShiftStep |=> tdo == IR_CAPTURE_VALUE[1])
		else $error("instruction not shifted lsb first");
	chk_ir_update: assert property ( // RULE13
		@(posedge tck) disable iff (rst) irLoad |=> t.ir == $past(t.irShift))
		else $error("instruction not taken on update");
	chk_shift_oe: assert property ( // RULE2
		@(posedge tck) disable iff (rst) (shiftStep or irShiftStep) |=> tdoOe)
		else $error("serial output not enabled while shifting");
	chk_disabled_quiet: assert property ( // RULE17
		@(posedge tck) disable iff (rst) !t.enSync[1] |=> !tdo && !tdoOe && !chipResetReq)
		else $error("disabled port still active");
	chk_bypass_shift: assert property ( // RULE4
		@(posedge tck) disable iff (rst)
		(shiftStep and t.ir == OP_BYPASS) ##1 (shiftStep and t.ir == OP_BYPASS)
		|-> tdo == $past(tdi))
		else $error("bypass not a single cell");
	chk_chain_capture: assert property ( // RULE21
		@(posedge tck) disable iff (rst) chainCapture
		|=> t.dr[1] == $past(pinIn[0]) && t.dr[0] == $past(padOe[0]))
		else $error("chain capture differs from pin and pad enable");
	chk_update_latch: assert property ( // RULE12
		@(posedge tck) disable iff (rst) latchLoad
		|=> t.bsOe[0] == $past(t.dr[0]) && t.bsOut[0] == $past(t.dr[1]))
		else $error("output latch not loaded on update");

	// checks on the core side
	chk_reset_stretch: assert property ( // RULE15
		@(posedge clk) disable iff (rst) $fell(c.rstSync[1]) |-> coreReset [*8])
		else $error("core reset released before time-out");
	chk_cause_flag: assert property ( // RULE19
		@(posedge clk) disable iff (rst) c.rstSync[1] |=> resetCause[RESET_FLAG_BIT])
		else $error("test reset flag not set");
	chk_single_write: assert property ( // RULE17
		@(posedge clk) disable iff (rst) ctrlWrite && c.armCount == '0
		|=> coreControl[DISABLE_BIT] == $past(coreControl[DISABLE_BIT]))
		else $error("disable bit changed on a single write");
	chk_disable_port: assert property ( // RULE17
		@(posedge clk) disable iff (rst) coreControl[DISABLE_BIT] |=> !tapEnable)
		else $error("port still enabled while disable bit set");
	chk_reset_follow: assert property ( // RULE14
		@(posedge clk) disable iff (rst) c.rstSync[1] |=> coreReset)
		else $error("core reset not raised by reset cell");
	chk_cause_clear: assert property ( // RULE19
		@(posedge clk) disable iff (rst)
		causeWrite && !writeData[RESET_FLAG_BIT] && !c.rstSync[1] |=> !resetCause[RESET_FLAG_BIT])
		else $error("test reset flag not cleared by write");
	chk_double_write: assert property ( // RULE17
		@(posedge clk) disable iff (rst)
		ctrlWrite && c.armCount != '0 && writeData[DISABLE_BIT] == c.armValue
		|=> coreControl[DISABLE_BIT] == $past(writeData[DISABLE_BIT]))
		else $error("disable bit not changed by a second write");
	chk_enable_follow: assert property ( // RULE17
		@(posedge clk) disable iff (rst) testPortFuse && !coreControl[DISABLE_BIT] |=> tapEnable)
		else $error("port not enabled with fuse set and bit clear");
	chk_test_pullup: assert property ( // RULE20
		@(posedge clk) disable iff (rst) testMode |-> padPullup == '0)
		else $error("pullup active in test mode");
	chk_reset_tristate: assert property ( // RULE16
		@(posedge clk) disable iff (rst) inReset && !extMode |-> padOe == '0)
		else $error("pad driven while chip held in reset");
	chk_extest_pads: assert property ( // RULE10
		@(posedge clk) disable iff (rst) extMode |-> padOut == t.bsOut && padOe == t.bsOe)
		else $error("pads not driven from chain latches");
	chk_sample_pads: assert property ( // RULE12
		@(posedge clk) disable iff (rst) sampleMode |-> padOut == portOut)
		else $error("sample mode disturbed the pads");
endmodule

// [design/boundary_scan_pkg.sv]
// Purpose: shared constants and carriers for the boundary-scan test logic
// Assumes: core clock of 25 MHz; test clock unrelated to it
// Notes: identification fields other than the version are arbitrary values
package boundary_scan_pkg;
	localparam int IR_WIDTH = 4;
	typedef logic [IR_WIDTH-1:0] opcode_t;

	// instruction codes
	localparam opcode_t OP_EXTEST = 4'h0;
	localparam opcode_t OP_IDCODE = 4'h1;
	localparam opcode_t OP_SAMPLE = 4'h2;
	localparam opcode_t OP_CHIP_RESET = 4'hc;
	localparam opcode_t OP_BYPASS = 4'hf;
	localparam opcode_t IR_CAPTURE_VALUE = 4'h1;

	// identification word fields
	localparam int ID_WIDTH = 32;
	localparam logic [3:0] ID_VERSION = 4'h0;
	localparam logic [15:0] ID_PART = 16'h5a3c; // arbitrary value
	localparam logic [10:0] ID_MAKER = 11'h2a5; // arbitrary value
	localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	// core register layout
	localparam int DISABLE_BIT = 7;
	localparam int RESET_FLAG_BIT = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [2:0] DISABLE_WINDOW = 3'h4;

	// start-up time-out after the test reset is released
	localparam int CLK_PERIOD_NS = 40;
	localparam int STARTUP_SHORT_NS = 1000;
	localparam int STARTUP_LONG_NS = 100000;
	localparam int STARTUP_SHORT_CYC = (STARTUP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_LONG_CYC = (STARTUP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_WIDTH = 12;

	// controller state indications, one level each, on the test clock
	typedef struct packed {
		logic tapReset;
		logic captureIr;
		logic shiftIr;
		logic updateIr;
		logic captureDr;
		logic shiftDr;
		logic updateDr;
	} tap_state_s;
endpackage

// [testbench/scan_controller.sv]
// Purpose: model of the external boundary-scan controller on the link
// Assumes: test clock of 30 ns, driven only inside frames
// Notes: tdi is inverted on release so a stale level never passes
`timescale 1ns/100ps
module scan_controller (
	// link wires
	output logic tck,
	output logic tdi,
	output boundary_scan_pkg::tap_state_s tapState,
	input wire logic tdo
);
	import boundary_scan_pkg::*;
	// idle link: clock still, no state asserted
	initial begin
		tck = 1'b0;
		tdi = 1'b0;
		tapState = '0;
	end
	// one test clock; state and data held across the rising edge
	task automatic step(input tap_state_s s, input logic din, output logic q);
		tapState = s;
		tdi = din;
		q = tdo;
		#15 tck = 1'b1;
		#15 tck = 1'b0;
	endtask
	// test-logic reset frame, long enough for the enable sync
	task automatic tapReset();
		logic q;
		repeat (5) step(7'h40, 1'b0, q);
		tapState = '0;
	endtask
	// capture, n shifts, update; ir picks the instruction path
	task automatic scan(input bit ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic [6:0] c;
		logic q;
		c = ir ? 7'h20 : 7'h04;
		dout = '0;
		step(c, 1'b0, q);
		for (int k = 0; k < n; k++) begin
			step(c >> 1, din[k], q);
			dout[k] = q;
		end
		step(c >> 2, 1'b0, q);
		tapState = '0;
		tdi = ~tdi;
	endtask
endmodule

// [testbench/boundary_scan_test_logic_tb_top.sv]
// Purpose: self-checking bench for the boundary-scan test logic
// Assumes: four pins, short start-up, test port and clock-out fuses set
// Notes: expectations come from a small model of latches and pins
`timescale 1ns/100ps
module boundary_scan_test_logic_tb_top;
	import boundary_scan_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic tck, tdi, tdo, tdoOe, tapEnable, chipResetReq, coreReset, clockOutEnable;
	tap_state_s tapState;
	logic ctrlWrite = 1'b0;
	logic causeWrite = 1'b0;
	logic pullupDisable = 1'b0;
	logic [7:0] writeData = 8'h00;
	logic [7:0] coreControl, resetCause, latch;
	logic [3:0] pinIn = 4'h0;
	logic [3:0] portOut = 4'h0;
	logic [3:0] portDir = 4'h0;
	logic [3:0] padOut, padOe, padPullup;
	logic [31:0] seed = 32'h5a;
	logic [31:0] r;
	logic [63:0] d;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int n;

	boundary_scan_test_logic #(.PIN_COUNT(4)) dut (.clk(clk), .rst(rst), .tck(tck),
		.tdi(tdi), .tapState(tapState), .tdo(tdo), .tdoOe(tdoOe), .tapEnable(tapEnable),
		.testPortFuse(1'b1), .clockOutFuse(1'b1), .longStartupFuse(1'b0),
		.ctrlWrite(ctrlWrite), .causeWrite(causeWrite), .writeData(writeData),
		.coreControl(coreControl), .resetCause(resetCause), .chipResetReq(chipResetReq),
		.coreReset(coreReset), .pinIn(pinIn), .portOut(portOut), .portDir(portDir),
		.pullupDisable(pullupDisable), .padOut(padOut), .padOe(padOe),
		.padPullup(padPullup), .clockOutEnable(clockOutEnable));
	scan_controller ctl (.tck(tck), .tdi(tdi), .tapState(tapState), .tdo(tdo));

	// core clock; the timeout guards against a hung handshake
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// pick control (sel 0) or data (sel 1) cells of the chain
	function automatic logic [3:0] field(input logic [7:0] l, input int sel);
		for (int i = 0; i < 4; i++)
			field[i] = l[2*i+sel];
	endfunction
	// chain capture: control cell takes pad enable, data cell the raw pin
	function automatic logic [7:0] capt(input logic [3:0] oe);
		for (int i = 0; i < 4; i++)
			capt[2*i+:2] = {pinIn[i], oe[i]};
	endfunction
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic setPins();
		r = rnd();
		@(posedge clk);
		pinIn <= r[3:0];
		portOut <= r[7:4];
		portDir <= r[11:8];
		pullupDisable <= r[12];
		@(negedge clk);
	endtask
	// c selects control register, otherwise reset cause
	task automatic wr(input logic c, input logic [7:0] v);
		@(posedge clk);
		ctrlWrite <= c;
		causeWrite <= !c;
		writeData <= v;
		@(posedge clk);
		ctrlWrite <= 1'b0;
		causeWrite <= 1'b0;
		@(negedge clk);
	endtask
	task automatic ldIr(input opcode_t c);
		ctl.scan(1'b1, 4, {60'h0, c}, d);
		check(d[3:0], IR_CAPTURE_VALUE);
	endtask

	initial begin
		rst <= 1'b1; // a real rising edge, so the idle test-clock side resets too
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10 && tapEnable !== 1'b1; i++)
			@(posedge clk);
		check(tapEnable, 1'b1);
		ctl.tapReset();
		ctl.scan(1'b0, 32, 64'h0, d);
		check(d[31:0], {4'h0, ID_PART, ID_MAKER, 1'b1});
		setPins();
		check(padPullup, ~{4{pullupDisable}} & ~portDir & portOut);
		check(clockOutEnable, 1'b1);
		// bypass and every code left undefined: one cell, zero first
		for (int c = 3; c < 16; c++) begin
			if (c != 12) begin
				ldIr(opcode_t'(c));
				r = rnd();
				ctl.scan(1'b0, 8, {32'h0, r}, d);
				check(d[7:0], {r[6:0], 1'b0});
			end
		end
		// sample: snapshot pins, preload latches, pads keep core values
		ldIr(OP_SAMPLE);
		setPins();
		check({padPullup, clockOutEnable}, 5'h0);
		r = rnd();
		ctl.scan(1'b0, 8, {32'h0, r}, d);
		check(d[7:0], capt(portDir));
		latch = r[7:0];
		check({padOut, padOe}, {portOut, portDir});
		// external test: latches reach pads as soon as the code lands
		ldIr(OP_EXTEST);
		check({padOut, padOe}, {field(latch, 1), field(latch, 0)});
		setPins();
		r = rnd();
		ctl.scan(1'b0, 8, {32'h0, r}, d);
		check(d[7:0], capt(field(latch, 0)));
		latch = r[7:0];
		check({padOut, padOe}, {field(latch, 1), field(latch, 0)});
		// chip reset cell: immediate reset, tri-state, cause flag, stretch
		ldIr(OP_CHIP_RESET);
		ctl.scan(1'b0, 1, 64'h1, d);
		check(chipResetReq, 1'b1);
		for (int i = 0; i < 10 && coreReset !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		check({coreReset, padOe, resetCause[4]}, 6'h21);
		ctl.scan(1'b0, 1, 64'h0, d);
		check(d[0], 1'b1);
		for (n = 0; coreReset === 1'b1 && n < 100; n++)
			@(negedge clk);
		check(n >= STARTUP_SHORT_CYC && n < STARTUP_SHORT_CYC + 8, 1'b1);
		wr(1'b0, 8'h00);
		check(resetCause[4], 1'b0);
		// disable bit: single write ignored, double write within four
		wr(1'b1, 8'h80);
		repeat (8) @(negedge clk);
		check(coreControl, 8'h00);
		wr(1'b1, 8'h80);
		wr(1'b1, 8'h80);
		repeat (2) @(negedge clk);
		check({coreControl, tapEnable}, {8'h80, 1'b0});
		ctl.tapReset(); // test clock must run for the disable to reach its side
		ctl.scan(1'b0, 8, 64'hff, d);
		check({d[7:0], tdoOe}, 9'h0);
		wr(1'b1, 8'h00);
		wr(1'b1, 8'h00);
		repeat (4) @(negedge clk);
		check(tapEnable, 1'b1);
		summarize();
	end
endmodule
